// [rtl/irq_ctrl_pkg.sv]
// shared constants and types for the eight-source interrupt controller
package irq_ctrl_pkg;
   localparam int unsigned NUM_REQ = 8;
   localparam int unsigned VEC_W   = 3;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 8;

   // register offsets, standard byte lanes
   localparam logic [7:0] OFF_TOP_PRIORITY_VECTOR   = 8'h00D0;
   localparam logic [7:0] OFF_PENDING_REQUEST_LATCH = 8'h00D1;
   localparam logic [7:0] OFF_SENSE_SELECT          = 8'h00D2;
   localparam logic [7:0] OFF_ENABLE_BITS           = 8'h00D3;
   localparam logic [7:0] OFF_PENDING_CLEAR_ON_READ = 8'h00D4;
   // register offsets, swapped byte lanes
   localparam logic [7:0] SW_OFF_PENDING_REQUEST_LATCH = 8'h00D0;
   localparam logic [7:0] SW_OFF_TOP_PRIORITY_VECTOR   = 8'h00D1;
   localparam logic [7:0] SW_OFF_ENABLE_BITS           = 8'h00D2;
   localparam logic [7:0] SW_OFF_SENSE_SELECT          = 8'h00D3;
   localparam logic [7:0] SW_OFF_PENDING_CLEAR_ON_READ = 8'h00D5;

   // reset values
   localparam logic [7:0] RST_SENSE_SELECT = 8'h0000;
   localparam logic [7:0] RST_ENABLE_BITS  = 8'h0000;
   localparam logic [7:0] RST_PENDING      = 8'h0000;
   localparam logic [7:0] RST_RDATA        = 8'h0000;
   // priority vector field position
   localparam int unsigned VEC_LSB = 0;

   // host access strobe group
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_t;

   // one interrupt macrocell configuration
   typedef struct packed {
      logic pol_a;    // invert first product term
      logic pol_b;    // invert second product term
      logic use_reg;  // registered output when set
   } cell_cfg_t;
endpackage

// [rtl/irq_cell.sv]
// one interrupt macrocell: two product terms, polarity, comb or registered
`timescale 1ns/1ps
`default_nettype none
module irq_cell (
   input  wire logic                   ref_clk,  // system clock
   input  wire logic                   nrst,     // async reset, active low
   input  wire logic                   term_a,   // first product term
   input  wire logic                   term_b,   // second product term
   input  wire irq_ctrl_pkg::cell_cfg_t cfg,     // polarity and mode
   output      logic                   cell_out  // request to controller
);
   logic pa;
   logic pb;
   logic sum_w;
   logic q_reg;

   // programmable polarity then or of both terms
   assign pa    = term_a ^ cfg.pol_a;
   assign pb    = term_b ^ cfg.pol_b;
   assign sum_w = pa | pb;

   // register mode flop
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) q_reg <= 1'b0;
      else       q_reg <= sum_w;
   end

   // mode select
   assign cell_out = cfg.use_reg ? q_reg : sum_w;
endmodule // irq_cell
`default_nettype wire

// [rtl/irq_ctrl.sv]
// eight-source interrupt controller with host register port
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl #(
   parameter int unsigned NUM_REQ = irq_ctrl_pkg::NUM_REQ  // request count
) (
   input  wire logic                    ref_clk,          // 250 MHz clock
   input  wire logic                    nrst,             // async reset, low
   input  wire logic                    io_region_select, // host chip select
   input  wire irq_ctrl_pkg::host_req_t host,             // host strobes
   input  wire logic                    swap_lanes,       // 16-bit swapped map
   output      logic [7:0]              rdata,            // read data
   input  wire logic [3:0]              terminal_count,   // timer tc outputs
   input  wire logic                    pterm_to_req_a,   // product term a
   input  wire logic                    pterm_to_req_b,   // product term b
   input  wire logic [1:0]              cell_terms_a,     // cell a terms
   input  wire logic [1:0]              cell_terms_b,     // cell b terms
   input  wire irq_ctrl_pkg::cell_cfg_t cell_cfg_a,       // cell a config
   input  wire irq_ctrl_pkg::cell_cfg_t cell_cfg_b,       // cell b config
   input  wire logic                    port_e_bit2_sel,  // pin special func
   output      logic                    global_irq_to_logic, // to array
   output      logic                    global_irq_pin,   // port e bit 2
   output      logic [7:0]              pending_view      // pending latch
);
   // elaboration check: register map fixed at eight bits
   if (NUM_REQ != 8) begin : g_bad_num
      $error("irq_ctrl supports exactly eight requests");
   end

   logic       cell_request_a;
   logic       cell_request_b;
   logic [7:0] req_in;
   logic [7:0] req_prev_reg;
   logic [7:0] sense_select_reg;
   logic [7:0] enable_bits_reg;
   logic [7:0] pending_reg;
   logic [7:0] pending_next;
   logic [7:0] rdata_next;
   logic       global_next;

   // macrocells feeding inputs six and seven
   irq_cell u_cell_a (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .term_a   (cell_terms_a[0]),
      .term_b   (cell_terms_a[1]),
      .cfg      (cell_cfg_a),
      .cell_out (cell_request_a)
   );

   irq_cell u_cell_b (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .term_a   (cell_terms_b[0]),
      .term_b   (cell_terms_b[1]),
      .cfg      (cell_cfg_b),
      .cell_out (cell_request_b)
   );

   // request vector; external events only via the array inputs
   assign req_in = {cell_request_b, cell_request_a,
                    pterm_to_req_b, pterm_to_req_a,
                    terminal_count};

   // address decode for both lane orders
   wire acc       = io_region_select;
   wire sel_vec   = acc & (swap_lanes ?
      host.addr == irq_ctrl_pkg::SW_OFF_TOP_PRIORITY_VECTOR :
      host.addr == irq_ctrl_pkg::OFF_TOP_PRIORITY_VECTOR);
   wire sel_latch = acc & (swap_lanes ?
      host.addr == irq_ctrl_pkg::SW_OFF_PENDING_REQUEST_LATCH :
      host.addr == irq_ctrl_pkg::OFF_PENDING_REQUEST_LATCH);
   wire sel_sense = acc & (swap_lanes ?
      host.addr == irq_ctrl_pkg::SW_OFF_SENSE_SELECT :
      host.addr == irq_ctrl_pkg::OFF_SENSE_SELECT);
   wire sel_en    = acc & (swap_lanes ?
      host.addr == irq_ctrl_pkg::SW_OFF_ENABLE_BITS :
      host.addr == irq_ctrl_pkg::OFF_ENABLE_BITS);
   wire sel_clr   = acc & (swap_lanes ?
      host.addr == irq_ctrl_pkg::SW_OFF_PENDING_CLEAR_ON_READ :
      host.addr == irq_ctrl_pkg::OFF_PENDING_CLEAR_ON_READ);

   // rising edge or level per sense bit, gated by enable
   wire [7:0] edge_w  = req_in & ~req_prev_reg;
   wire [7:0] hit_w   = (sense_select_reg & req_in) |
                        (~sense_select_reg & edge_w);
   wire [7:0] set_w   = hit_w & enable_bits_reg;
   wire [7:0] active_w = pending_reg & enable_bits_reg;

   // priority encoder, seven wins
   logic [2:0] top_w;
   logic       any_w;
   always_comb begin
      top_w = 3'h0;
      any_w = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (active_w[i]) begin
            top_w = 3'(i);
            any_w = 1'b1;
         end
      end
   end

   wire [7:0] top_onehot = any_w ? (8'h0001 << top_w) : 8'h0000;

   // clears from host reads; edge-sensed bits only for clear-on-read
   wire rd_vec = host.rd & sel_vec;
   wire rd_clr = host.rd & sel_clr;
   wire [7:0] clr_w = (rd_clr ? ~sense_select_reg : 8'h0000)
                    | (rd_vec ? top_onehot : 8'h0000);

   // pending next: new set wins over a same-cycle clear
   assign pending_next = (pending_reg & ~clr_w) | set_w;

   // read mux; reserved and unmapped read zero
   always_comb begin
      rdata_next = irq_ctrl_pkg::RST_RDATA;
      if (host.rd) begin
         if (sel_vec)
            rdata_next = {5'h00, top_w};
         else if (sel_latch)
            rdata_next = pending_reg;
         else if (sel_sense)
            rdata_next = sense_select_reg;
         else if (sel_en)
            rdata_next = enable_bits_reg;
         else if (sel_clr)
            rdata_next = pending_reg;
      end
   end

   // global interrupt level
   assign global_next = |(pending_next & enable_bits_reg);

   // previous input sample for edge detection
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) req_prev_reg <= 8'h0000;
      else       req_prev_reg <= req_in;
   end

   // configuration registers; clear-on-read ignores writes
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sense_select_reg <= irq_ctrl_pkg::RST_SENSE_SELECT;
         enable_bits_reg  <= irq_ctrl_pkg::RST_ENABLE_BITS;
      end else if (host.wr) begin
         if (sel_sense) sense_select_reg <= host.wdata;
         if (sel_en)    enable_bits_reg  <= host.wdata;
      end
   end

   // pending latch
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) pending_reg <= irq_ctrl_pkg::RST_PENDING;
      else       pending_reg <= pending_next;
   end

   // registered outputs
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdata               <= irq_ctrl_pkg::RST_RDATA;
         global_irq_to_logic <= 1'b0;
         global_irq_pin      <= 1'b0;
         pending_view        <= irq_ctrl_pkg::RST_PENDING;
      end else begin
         rdata               <= rdata_next;
         global_irq_to_logic <= global_next;
         global_irq_pin      <= global_next & port_e_bit2_sel;
         pending_view        <= pending_next;
      end
   end
endmodule // irq_ctrl
`default_nettype wire

// [dv/irq_ctrl_assertions.sv]
// port-level properties of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker (
   input wire logic                    ref_clk,             // clock
   input wire logic                    nrst,                // reset, low
   input wire logic                    io_region_select,    // host select
   input wire irq_ctrl_pkg::host_req_t host,                // strobes
   input wire logic                    swap_lanes,          // map select
   input wire logic [7:0]              rdata,               // read data
   input wire logic                    port_e_bit2_sel,     // pin function
   input wire logic                    global_irq_to_logic, // global
   input wire logic                    global_irq_pin,      // pin copy
   input wire logic [7:0]              pending_view         // latch
);
   // read decode for both maps
   wire       rd = io_region_select && host.rd;
   wire [7:0] a  = host.addr;
   wire       pr = rd && a == (swap_lanes ? 8'hd1 : 8'hd0);
   wire       lt = rd && a == (swap_lanes ? 8'hd0 : 8'hd1);
   wire       cl = rd && a == (swap_lanes ? 8'hd5 : 8'hd4);
   wire       mp = pr || lt || cl || (rd && (a == 8'hd2 || a == 8'hd3));
   wire       ac = io_region_select && (host.rd || host.wr);
   // latch value seen at the read edge
   logic [7:0] pv_q;
   always_ff @(posedge ref_clk) pv_q <= pending_view;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_pin;
      global_irq_pin == (global_irq_to_logic && $past(port_e_bit2_sel));
   endproperty
   a_pin: assert property (p_pin) else $error("pin copy wrong");
   property p_glob; global_irq_to_logic |-> pending_view != 0; endproperty
   a_glob: assert property (p_glob) else $error("global idle");
   property p_rsv; pr |=> rdata[7:3] == 0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   property p_idle; !mp |=> rdata == 0; endproperty
   a_idle: assert property (p_idle) else $error("stray data");
   property p_lat; lt |=> rdata == pv_q; endproperty
   a_lat: assert property (p_lat) else $error("latch read");
   property p_clr; cl |=> rdata == pv_q; endproperty
   a_clr: assert property (p_clr) else $error("clear read");
   property p_vec; pr && global_irq_to_logic |=> pv_q[rdata[2:0]]; endproperty
   a_vec: assert property (p_vec) else $error("vector idle");
   property p_none; pr && !global_irq_to_logic |=> rdata == 0; endproperty
   a_none: assert property (p_none) else $error("vector nonzero");
   property p_fell; $fell(global_irq_to_logic) |-> $past(ac); endproperty
   a_fell: assert property (p_fell) else $error("global fell");
   // main scenarios
   c_pr:  cover property (pr && global_irq_to_logic);
   c_cl:  cover property (cl && pending_view != 0);
   c_pin: cover property (global_irq_pin);
endmodule // irq_ctrl_checker
bind irq_ctrl irq_ctrl_checker chk (.ref_clk, .nrst, .io_region_select,
   .host, .swap_lanes, .rdata, .port_e_bit2_sel, .global_irq_to_logic,
   .global_irq_pin, .pending_view);
`default_nettype wire

// [dv/irq_src_model.sv]
// request sources: timers, product terms, macrocell terms
`timescale 1ns/1ps
`default_nettype none
module irq_src_model (
   input  wire logic [7:0] want,           // wanted request levels
   output logic [3:0]      terminal_count, // timer counts
   output logic            pterm_to_req_a, // term for request 4
   output logic            pterm_to_req_b, // term for request 5
   output logic [1:0]      cell_terms_a,   // cell a, plain terms
   output logic [1:0]      cell_terms_b    // cell b, inverted terms
);
   // fixed slots; outside events only through logic terms
   assign terminal_count = want[3:0];
   assign pterm_to_req_a = want[4];
   assign pterm_to_req_b = want[5];
   // cell a ors plain terms, cell b needs both terms inverted
   assign cell_terms_a = {want[6], 1'b0};
   assign cell_terms_b = {2{~want[7]}};
endmodule // irq_src_model
`default_nettype wire

// [dv/eight_source_irq_controller_test.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module eight_source_irq_controller_test;
   logic ref_clk = 0, nrst = 0, sel = 0, swap = 0, pe = 0;
   irq_ctrl_pkg::host_req_t host = '0;
   irq_ctrl_pkg::cell_cfg_t cfga = '0, cfgb = 3'h6;
   logic [7:0] want = '0, d, en, sn, r, p;
   wire logic [7:0] rdata, pv;
   wire logic [3:0] tc;
   wire logic [1:0] ca, cb;
   wire logic       pa, pb, gl, pin;
   int err_count = 0, cmp_count = 0;
   irq_src_model src (.want, .terminal_count(tc), .pterm_to_req_a(pa),
      .pterm_to_req_b(pb), .cell_terms_a(ca), .cell_terms_b(cb));
   irq_ctrl DUT (.ref_clk, .nrst, .io_region_select(sel), .host,
      .swap_lanes(swap), .rdata, .terminal_count(tc), .pterm_to_req_a(pa),
      .pterm_to_req_b(pb), .cell_terms_a(ca), .cell_terms_b(cb),
      .cell_cfg_a(cfga), .cell_cfg_b(cfgb), .port_e_bit2_sel(pe),
      .global_irq_to_logic(gl), .global_irq_pin(pin), .pending_view(pv));
   initial forever #2 ref_clk = ~ref_clk;
   // compare and count
   task chk(input logic [7:0] s, e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, s, e);
      end
   endtask
   // one host access, read data left in d
   task acc(input logic w, input logic [7:0] a, wd);
      @(posedge ref_clk) #1;
      sel = 1;
      host = '{~w, w, a, wd};
      @(posedge ref_clk) #1;
      sel = 0;
      host = '0;
      d = rdata;
   endtask
   task rst;
      nrst = 0;
      repeat (16) @(posedge ref_clk);
      #1 nrst = 1;
   endtask
   // number of the highest set bit
   function logic [2:0] top(input logic [7:0] v);
      top = 0;
      for (int i = 0; i < 8; i++) if (v[i]) top = i;
   endfunction
   // offset by index for the current lane order
   // 0 vector, 1 latch, 2 sense, 3 enable, 4 clear
   function logic [7:0] ofs(input int k);
      case (k)
         0: ofs = swap ? 8'hd1 : 8'hd0;
         1: ofs = swap ? 8'hd0 : 8'hd1;
         2: ofs = swap ? 8'hd3 : 8'hd2;
         3: ofs = swap ? 8'hd2 : 8'hd3;
         default: ofs = swap ? 8'hd5 : 8'hd4;
      endcase
   endfunction
   task wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      wrap_up;
   end
   // main sequence
   initial begin
      void'($urandom(32'h0000_ead3));
      rst;
      for (int a = 8'hd0; a < 8'hd7; a++) begin
         acc(0, a[7:0], 0);
         chk(d, 0);
      end
      $display("test reset done");
      en = $urandom;
      sn = $urandom;
      acc(1, 8'hd3, en);
      acc(1, 8'hd2, sn);
      acc(0, 8'hd3, 0); chk(d, en);
      acc(0, 8'hd2, 0); chk(d, sn);
      swap = 1;
      acc(0, 8'hd2, 0); chk(d, en);
      acc(0, 8'hd3, 0); chk(d, sn);
      swap = 0;
      $display("test registers done");
      repeat (4) begin
         en = $urandom;
         r = $urandom;
         pe = $urandom;
         {cfga.use_reg, cfgb.use_reg} = 2'($urandom);
         acc(1, 8'hd3, en);
         acc(1, 8'hd2, 0);
         @(posedge ref_clk) #1 want = r;
         @(posedge ref_clk) #1 want = 0;
         @(posedge ref_clk) #1 p = r & en;
         chk(pv, p);
         chk(gl, |p);
         chk(pin, |p & pe);
         while (p != 0) begin
            acc(0, 8'hd0, 0); chk(d, top(p));
            p[top(p)] = 0;
         end
         acc(0, 8'hd0, 0); chk(d, 0);
         chk(pv, 0);
      end
      $display("test priority done");
      repeat (4) begin
         sn = $urandom;
         r = $urandom;
         swap = 1'($urandom);
         {cfga.use_reg, cfgb.use_reg} = 2'($urandom);
         acc(1, ofs(3), 8'hff);
         acc(1, ofs(2), sn);
         @(posedge ref_clk) #1 want = r;
         repeat (2) @(posedge ref_clk);
         #1 chk(pv, r);
         acc(0, ofs(1), 0); chk(d, r);
         acc(1, ofs(4), 8'h00); chk(pv, r);
         acc(0, ofs(4), 0); chk(d, r);
         chk(pv, r & sn);
         acc(0, ofs(0), 0); chk(d, top(r & sn));
         chk(pv, r & sn);
         want = 0;
         rst;
         chk(pv, 0);
      end
      $display("test sense done");
      wrap_up;
   end
endmodule // eight_source_irq_controller_test
`default_nettype wire
